// [verilog/sysctl_slice_pkg.sv]
// Shared constants, codes and decode functions for the system-control slice
package sysctl_slice_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 100;
   // Width of the device reset pulse issued for a software request
   localparam int unsigned SW_RESET_HOLD_NS = 1000;
   localparam int unsigned SW_RESET_HOLD_CYCLES =
      (SW_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_CNT_WIDTH = 4;

   // ************************************************************
   // Reset-cause flag layout
   // ************************************************************
   localparam int unsigned CAUSE_WIDTH = 6;
   localparam int unsigned CAUSE_EXTERNAL_PIN_BIT = 0;
   localparam int unsigned CAUSE_POWER_ON_BIT = 1;
   localparam int unsigned CAUSE_BROWNOUT_BIT = 2;
   localparam int unsigned CAUSE_WATCHDOG_EXPIRY_BIT = 3;
   localparam int unsigned CAUSE_SOFTWARE_REQUEST_BIT = 4;
   localparam int unsigned CAUSE_REGULATOR_FAULT_BIT = 5;
   // Power-on is the only reset seen by resetn itself
   localparam logic [5:0] CAUSE_RESET_VALUE = 6'h02;

   // ************************************************************
   // Configuration defaults
   // ************************************************************
   localparam logic GATING_EN_RESET = 1'b0;
   localparam logic WAVE_DIV_WIDTH_DUMMY = 1'b0;
   localparam int unsigned WAVE_DIV_WIDTH = 3;
   localparam int unsigned WAVE_CNT_WIDTH = 6;

   // Waveform clock ratio codes
   localparam logic [2:0] WAVE_CLK_DIV_1 = 3'h0;
   localparam logic [2:0] WAVE_CLK_DIV_2 = 3'h1;
   localparam logic [2:0] WAVE_CLK_DIV_4 = 3'h2;
   localparam logic [2:0] WAVE_CLK_DIV_8 = 3'h3;
   localparam logic [2:0] WAVE_CLK_DIV_16 = 3'h4;
   localparam logic [2:0] WAVE_CLK_DIV_32 = 3'h5;
   localparam logic [2:0] WAVE_CLK_DIV_64 = 3'h6;
   localparam logic [2:0] WAVE_DIV_RESET = WAVE_CLK_DIV_1;

   // ************************************************************
   // Optional pin presence layout
   // ************************************************************
   localparam int unsigned PIN_COUNT = 33;
   localparam int unsigned WAVE_OUT_PIN_LSB = 0;
   localparam int unsigned MOTOR_FAULT_PIN_BIT = 6;
   localparam int unsigned COMPARATOR_PIN_LSB = 7;
   localparam int unsigned CONVERTER_PIN_LSB = 16;
   localparam int unsigned CAPTURE_PIN_LSB = 24;
   localparam int unsigned SLOW_CLOCK_PIN_BIT = 32;

   typedef enum logic {ST_RUN, ST_SLEEP} power_state_type;

   function automatic logic wave_div_valid(input logic [2:0] code);
      return code <= WAVE_CLK_DIV_64;
   endfunction

   // Low counter bits that must all be one for a divided tick
   function automatic logic [5:0] wave_div_mask(input logic [2:0] code);
      logic [6:0] full;
      full = (7'h01 << code) - 7'h01;
      return full[5:0];
   endfunction

endpackage

// [verilog/periph_clk_gate.sv]
// Per-peripheral clock-enable cells for run and sleep gating
`timescale 1ns/1ps
`default_nettype none
module periph_clk_gate
   import sysctl_slice_pkg::*;
#(
   parameter int unsigned PERIPH_COUNT = 32
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sleeping,
   input wire logic gating_en,
   input wire logic [PERIPH_COUNT-1:0] run_en,
   input wire logic [PERIPH_COUNT-1:0] sleep_en,
   output logic [PERIPH_COUNT-1:0] clk_en
);

   // Enables change at the rising clock edge, while the clock is high, so a clock gated
   // by them can see a shortened high phase; the cell is a registered enable, not a glitch-free gate
   genvar i;
   generate
      for (i = 0; i < PERIPH_COUNT; i++) begin : g_cell
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               clk_en[i] <= 1'b0;
            end else begin
               clk_en[i] <= run_en[i] & (~sleeping | ~gating_en | sleep_en[i]);
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// [verilog/wave_clk_divider.sv]
// Power-of-two clock-enable divider for the waveform module
`timescale 1ns/1ps
`default_nettype none
module wave_clk_divider
   import sysctl_slice_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [2:0] div_sel,
   output logic tick
);

   logic [WAVE_CNT_WIDTH-1:0] count_reg;

   // Counter never stops or reloads, so a ratio change takes effect at once and can cut the current period
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick <= 1'b0;
      end else begin
         tick <= (count_reg & wave_div_mask(div_sel)) == wave_div_mask(div_sel);
      end
   end

endmodule
`default_nettype wire

// [verilog/sysctl_slice.sv]
// Sleep gating, waveform clock, software reset and reset-cause flags
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Sleep stops peripherals without sleep enable
// - Stopped peripherals resume after sleep, state kept
// - Sleep-enabled peripherals keep clock in sleep
// - Running peripheral wake event ends sleep
// - Sleep enables act only with master gating
// - Waveform clock is system clock over 1..64
// - Divide setting reads back as ratio code
// - Waveform clock follows system clock rate
// - Software reset resets whole device to defaults
// - Software reset keeps cause flags, adds own
// - Each reset cause has its own flag
// - Cause flags clear selectively by mask
// - Flags stick until cleared, then set again
// - Optional pin presence readable, read-only
// - External-pin reset clears flags, others persist
module sysctl_slice
   import sysctl_slice_pkg::*;
#(
   parameter int unsigned PERIPH_COUNT = 32,
   // Presence pattern of this part; all present is an arbitrary default
   parameter logic [PIN_COUNT-1:0] PIN_PRESENT_MAP = {PIN_COUNT{1'b1}}
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sleep_req,
   input wire logic [PERIPH_COUNT-1:0] periph_wake,
   input wire logic [PERIPH_COUNT-1:0] run_en,
   input wire logic sleep_en_wr,
   input wire logic [PERIPH_COUNT-1:0] sleep_en_wdata,
   input wire logic gating_en_wr,
   input wire logic gating_en_wdata,
   input wire logic wave_div_wr,
   input wire logic [2:0] wave_div_wdata,
   input wire logic sw_reset_req,
   input wire logic cause_clr,
   input wire logic [CAUSE_WIDTH-1:0] cause_clr_mask,
   input wire logic ext_pin_reset,
   input wire logic brownout_reset,
   input wire logic watchdog_reset,
   input wire logic regulator_reset,
   output logic cpu_sleeping,
   output logic cpu_wake,
   output logic [PERIPH_COUNT-1:0] periph_clk_en,
   output logic [PERIPH_COUNT-1:0] sleep_en_rd,
   output logic gating_en_rd,
   output logic [2:0] wave_div_rd,
   output logic wave_clk_en,
   output logic device_reset_n,
   output logic [CAUSE_WIDTH-1:0] cause_rd,
   output logic [PIN_COUNT-1:0] pin_present
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (PERIPH_COUNT < 1 || PERIPH_COUNT > 64) begin : g_bad_count
      $error("PERIPH_COUNT must lie between 1 and 64");
   end
   if (SW_RESET_HOLD_CYCLES >= (1 << RESET_CNT_WIDTH)) begin : g_bad_hold
      $error("Reset hold count does not fit its counter");
   end

   localparam logic [RESET_CNT_WIDTH-1:0] HOLD_LOAD = RESET_CNT_WIDTH'(SW_RESET_HOLD_CYCLES);

   // ************************************************************
   // Device reset sequencing
   // ************************************************************
   logic dev_reset_event;
   logic [RESET_CNT_WIDTH-1:0] hold_cnt_reg;
   power_state_type state_reg;
   logic [PERIPH_COUNT-1:0] sleep_en_reg;
   logic gating_en_reg;
   logic [2:0] wave_div_reg;
   logic [CAUSE_WIDTH-1:0] cause_reg;
   logic [CAUSE_WIDTH-1:0] cause_set;
   logic wake_hit;

   // Any reset source restarts the device; this block's own settings follow
   assign dev_reset_event = sw_reset_req | ext_pin_reset | brownout_reset |
                            watchdog_reset | regulator_reset;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if (dev_reset_event) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if (hold_cnt_reg != '0) begin
         hold_cnt_reg <= hold_cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         device_reset_n <= 1'b0;
      end else begin
         device_reset_n <= ~dev_reset_event & (hold_cnt_reg <= 4'h1);
      end
   end

   // ************************************************************
   // Sleep state
   // ************************************************************
   // wake only from clocked peripherals
   assign wake_hit = |(periph_wake & periph_clk_en);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_RUN;
      end else if (dev_reset_event) begin
         state_reg <= ST_RUN;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (sleep_req) begin
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wake_hit) begin
                  state_reg <= ST_RUN;
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpu_sleeping <= 1'b0;
         cpu_wake <= 1'b0;
      end else begin
         cpu_sleeping <= (state_reg == ST_SLEEP) & ~wake_hit & ~dev_reset_event;
         cpu_wake <= (state_reg == ST_SLEEP) & wake_hit & ~dev_reset_event;
      end
   end

   // ************************************************************
   // Configuration settings, restored on every device reset
   // ************************************************************
   // enables stored regardless of gating
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sleep_en_reg <= '0;
      end else if (dev_reset_event) begin
         sleep_en_reg <= '0;
      end else if (sleep_en_wr) begin
         sleep_en_reg <= sleep_en_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gating_en_reg <= GATING_EN_RESET;
      end else if (dev_reset_event) begin
         gating_en_reg <= GATING_EN_RESET;
      end else if (gating_en_wr) begin
         gating_en_reg <= gating_en_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wave_div_reg <= WAVE_DIV_RESET;
      end else if (dev_reset_event) begin
         wave_div_reg <= WAVE_DIV_RESET;
      end else if (wave_div_wr && wave_div_valid(wave_div_wdata)) begin
         wave_div_reg <= wave_div_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sleep_en_rd <= '0;
         gating_en_rd <= GATING_EN_RESET;
         wave_div_rd <= WAVE_DIV_RESET;
      end else begin
         sleep_en_rd <= sleep_en_reg;
         gating_en_rd <= gating_en_reg;
         wave_div_rd <= wave_div_reg;
      end
   end

   // ************************************************************
   // Clock gating and waveform clock
   // ************************************************************
   // gate cells per peripheral
   periph_clk_gate #(
      .PERIPH_COUNT(PERIPH_COUNT)
   ) u_gate (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .sleeping(state_reg == ST_SLEEP),
      .gating_en(gating_en_reg),
      .run_en(run_en),
      .sleep_en(sleep_en_reg),
      .clk_en(periph_clk_en)
   );

   // divider runs from the system clock
   wave_clk_divider u_wave_div (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .div_sel(wave_div_reg),
      .tick(wave_clk_en)
   );

   // ************************************************************
   // Reset-cause flags
   // ************************************************************
   always_comb begin
      cause_set = '0;
      cause_set[CAUSE_SOFTWARE_REQUEST_BIT] = sw_reset_req;
      cause_set[CAUSE_BROWNOUT_BIT] = brownout_reset;
      cause_set[CAUSE_WATCHDOG_EXPIRY_BIT] = watchdog_reset;
      cause_set[CAUSE_REGULATOR_FAULT_BIT] = regulator_reset;
      cause_set[CAUSE_EXTERNAL_PIN_BIT] = ext_pin_reset;
   end

   // external pin wipes the older flags
   // masked clear; a new cause wins over it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cause_reg <= CAUSE_RESET_VALUE;
      end else if (ext_pin_reset) begin
         cause_reg <= cause_set;
      end else if (cause_clr) begin
         cause_reg <= (cause_reg & ~cause_clr_mask) | cause_set;
      end else begin
         cause_reg <= cause_reg | cause_set;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cause_rd <= CAUSE_RESET_VALUE;
      end else begin
         cause_rd <= cause_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_present <= '0;
      end else begin
         pin_present <= PIN_PRESENT_MAP;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_asleep_gated;
      state_reg == ST_SLEEP && gating_en_reg && !dev_reset_event;
   endsequence
   sequence s_sw_request;
      sw_reset_req;
   endsequence

   chk_sleep_stops_clk: assert property (
      s_asleep_gated ##0 (run_en[0] && !sleep_en_reg[0]) |=> !periph_clk_en[0])
      else $error("Peripheral clock ran in sleep without its enable");

   chk_wake_resumes_clk: assert property (
      state_reg == ST_RUN && run_en[0] |=> periph_clk_en[0])
      else $error("Run-enabled peripheral not clocked in run mode");

   chk_sleep_keeps_clk: assert property (
      state_reg == ST_SLEEP && run_en[0] && sleep_en_reg[0] |=> periph_clk_en[0])
      else $error("Sleep-enabled peripheral lost its clock");

   chk_wake_event_exit: assert property (
      state_reg == ST_SLEEP && wake_hit && !dev_reset_event
      |=> cpu_wake && state_reg == ST_RUN)
      else $error("Wake event did not return to run mode");

   chk_gating_off_runs: assert property (
      !gating_en_reg && run_en[0] |=> periph_clk_en[0])
      else $error("Peripheral stopped while master gating off");

   chk_div_code_valid: assert property (
      wave_div_valid(wave_div_rd))
      else $error("Divide readback outside the seven codes");

   chk_div64_tick: assert property (
      wave_div_reg == WAVE_CLK_DIV_64 && $stable(wave_div_reg) && wave_clk_en
      |=> !wave_clk_en)
      else $error("Waveform tick repeated at divide by 64");

   chk_div1_tick: assert property (
      wave_div_reg == WAVE_CLK_DIV_1 ##1 wave_div_reg == WAVE_CLK_DIV_1
      |-> wave_clk_en)
      else $error("Waveform tick missing at divide by 1");

   chk_sw_reset_pulse: assert property (
      s_sw_request |=> !device_reset_n [*8])
      else $error("Software reset pulse too short");

   chk_sw_keeps_flags: assert property (
      s_sw_request ##0 !ext_pin_reset && !cause_clr
      |=> (cause_reg & $past(cause_reg)) == $past(cause_reg)
          && cause_reg[CAUSE_SOFTWARE_REQUEST_BIT])
      else $error("Software reset lost cause flags");

   chk_clear_masked: assert property (
      cause_clr && !ext_pin_reset && !dev_reset_event
      |=> cause_reg == ($past(cause_reg) & ~$past(cause_clr_mask)))
      else $error("Cause clear touched unnamed flags");

   chk_flag_sticky: assert property (
      !cause_clr && !ext_pin_reset |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
      else $error("Cause flag dropped without a clear");

   chk_watchdog_flag: assert property (
      watchdog_reset |=> cause_reg[CAUSE_WATCHDOG_EXPIRY_BIT])
      else $error("Watchdog reset not recorded");

   chk_ext_clears: assert property (
      ext_pin_reset && !sw_reset_req && !brownout_reset && !watchdog_reset
      && !regulator_reset |=> cause_reg == 6'h01)
      else $error("External reset did not clear older flags");

   chk_reset_defaults: assert property (
      dev_reset_event |=> sleep_en_reg == '0 && !gating_en_reg
                          && wave_div_reg == WAVE_DIV_RESET)
      else $error("Settings not restored by device reset");

endmodule
`default_nettype wire

// [testbench/periph_model.sv]
// Behavioural model of the gated peripherals beside the slice
`timescale 1ns/1ps
`default_nettype none
module periph_model #(
   parameter int unsigned PERIPH_COUNT = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [PERIPH_COUNT-1:0] clk_en,
   input wire logic [PERIPH_COUNT-1:0] wake_cmd,
   output logic [PERIPH_COUNT-1:0] periph_wake,
   output logic [8*PERIPH_COUNT-1:0] activity
);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         activity <= '0;
      end else begin
         for (int i = 0; i < PERIPH_COUNT; i++) begin
            if (clk_en[i]) begin
               activity[8*i +: 8] <= activity[8*i +: 8] + 8'h01;
            end
         end
      end
   end
   // Wake raised on command
   // Raised even when stopped, so the slice must do the filtering itself
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         periph_wake <= '0;
      end else begin
         periph_wake <= wake_cmd;
      end
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the system-control slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sysctl_slice_pkg::*;
   localparam int unsigned NP = 4;
   localparam logic [32:0] PIN_MAP = 33'h1_2345_6789;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic sleep_req = 1'b0, sleep_en_wr = 1'b0, gating_en_wr = 1'b0, gating_en_wdata = 1'b0;
   logic wave_div_wr = 1'b0, sw_reset_req = 1'b0, cause_clr = 1'b0;
   logic ext_pin_reset = 1'b0, brownout_reset = 1'b0, watchdog_reset = 1'b0;
   logic regulator_reset = 1'b0;
   logic [NP-1:0] run_en = '1, sleep_en_wdata = '0, wake_cmd = '0, periph_wake, periph_clk_en;
   logic [NP-1:0] sleep_en_rd;
   logic [2:0] wave_div_wdata = 3'h0, wave_div_rd;
   logic [CAUSE_WIDTH-1:0] cause_clr_mask = '0, cause_rd;
   logic cpu_sleeping, cpu_wake, gating_en_rd, wave_clk_en, device_reset_n;
   logic [PIN_COUNT-1:0] pin_present;
   logic [8*NP-1:0] activity;
   int err_count = 0;
   int total_checks = 0;

   always #50 clk_sys = ~clk_sys;

   sysctl_slice #(.PERIPH_COUNT(NP), .PIN_PRESENT_MAP(PIN_MAP)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .sleep_req(sleep_req), .periph_wake(periph_wake),
      .run_en(run_en), .sleep_en_wr(sleep_en_wr), .sleep_en_wdata(sleep_en_wdata),
      .gating_en_wr(gating_en_wr), .gating_en_wdata(gating_en_wdata),
      .wave_div_wr(wave_div_wr), .wave_div_wdata(wave_div_wdata),
      .sw_reset_req(sw_reset_req), .cause_clr(cause_clr), .cause_clr_mask(cause_clr_mask),
      .ext_pin_reset(ext_pin_reset), .brownout_reset(brownout_reset),
      .watchdog_reset(watchdog_reset), .regulator_reset(regulator_reset),
      .cpu_sleeping(cpu_sleeping), .cpu_wake(cpu_wake), .periph_clk_en(periph_clk_en),
      .sleep_en_rd(sleep_en_rd), .gating_en_rd(gating_en_rd), .wave_div_rd(wave_div_rd),
      .wave_clk_en(wave_clk_en), .device_reset_n(device_reset_n), .cause_rd(cause_rd),
      .pin_present(pin_present)
   );

   periph_model #(.PERIPH_COUNT(NP)) i_periph (
      .clk_sys(clk_sys), .resetn(resetn), .clk_en(periph_clk_en), .wake_cmd(wake_cmd),
      .periph_wake(periph_wake), .activity(activity)
   );

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks made %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic set_cfg(input logic [NP-1:0] sl, input logic gt);
      sleep_en_wdata = sl;
      gating_en_wdata = gt;
      sleep_en_wr = 1'b1;
      gating_en_wr = 1'b1;
      step(1);
      sleep_en_wr = 1'b0;
      gating_en_wr = 1'b0;
      step(2);
   endtask

   task automatic set_div(input logic [2:0] code);
      wave_div_wdata = code;
      wave_div_wr = 1'b1;
      step(1);
      wave_div_wr = 1'b0;
      step(2);
   endtask

   task automatic go_sleep();
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
      step(2);
      check("cpu_sleeping", cpu_sleeping, 1'b1);
   endtask

   task automatic wake_by(input int p);
      bit got;
      got = 1'b0;
      wake_cmd[p] = 1'b1;
      for (int i = 0; i < 8 && !got; i++) begin
         step(1);
         got = (cpu_wake === 1'b1);
      end
      wake_cmd = '0;
      check("cpu_wake", got, 1'b1);
      check("cpu_sleeping", cpu_sleeping, 1'b0);
   endtask

   // Event codes: 0 ext pin, 1 brown-out, 2 watchdog, 3 regulator, 4 software
   task automatic fire(input int k, output int lows);
      ext_pin_reset = (k == 0);
      brownout_reset = (k == 1);
      watchdog_reset = (k == 2);
      regulator_reset = (k == 3);
      sw_reset_req = (k == 4);
      step(1);
      {ext_pin_reset, brownout_reset, watchdog_reset, regulator_reset, sw_reset_req} = '0;
      lows = 0;
      for (int i = 0; i < 30; i++) begin
         step(1);
         if (device_reset_n === 1'b0) lows++;
      end
   endtask

   task automatic clear_causes(input logic [5:0] m);
      cause_clr_mask = m;
      cause_clr = 1'b1;
      step(1);
      cause_clr = 1'b0;
      step(3);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      logic [7:0] held;
      logic [5:0] exp;
      int n;
      int lows;
      int ev[4] = '{3, 2, 1, 4};
      int bitpos[4] = '{5, 3, 2, 4};
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      resetn = 1'b1;
      check("cause_rd", cause_rd, 6'h02);
      check("wave_div_rd", wave_div_rd, WAVE_CLK_DIV_1);
      check("gating_en_rd", gating_en_rd, 1'b0);
      check("device_reset_n", device_reset_n, 1'b0);
      step(20);
      check("device_reset_n", device_reset_n, 1'b1);
      check("pin_present", pin_present, PIN_MAP);
      $display("test reset values done");

      set_cfg(4'b0101, 1'b1);
      check("sleep_en_rd", sleep_en_rd, 4'b0101);
      check("gating_en_rd", gating_en_rd, 1'b1);
      go_sleep();
      check("periph_clk_en", periph_clk_en, 4'b0101);
      held = activity[15:8];
      n = activity[7:0];
      wake_cmd[1] = 1'b1;
      step(5);
      wake_cmd = '0;
      check("stopped wake refused", cpu_sleeping, 1'b1);
      check("running peripheral", activity[7:0], n + 5);
      check("stopped peripheral", activity[15:8], held);
      wake_by(0);
      step(2);
      check("periph_clk_en", periph_clk_en, 4'b1111);
      step(3);
      // Clocked again on four edges: the one before the enable check and three more
      check("resumed peripheral", activity[15:8], held + 4);
      $display("test sleep gating done");

      set_cfg(4'b0101, 1'b0);
      check("sleep_en_rd", sleep_en_rd, 4'b0101);
      go_sleep();
      check("periph_clk_en", periph_clk_en, 4'b1111);
      wake_by(2);
      $display("test gating off done");

      for (int c = 0; c < 7; c++) begin
         set_div(c[2:0]);
         check("wave_div_rd", wave_div_rd, c);
         step(70);
         n = 0;
         for (int j = 0; j < 128; j++) begin
            if (wave_clk_en === 1'b1) n++;
            step(1);
         end
         check("wave ticks", n, 128 >> c);
      end
      set_div(3'h7);
      check("wave_div_rd", wave_div_rd, WAVE_CLK_DIV_64);
      $display("test waveform clock done");

      fire(2, lows);
      check("cause_rd", cause_rd, 6'h0a);
      check("wave_div_rd", wave_div_rd, WAVE_CLK_DIV_1);
      set_cfg(4'b0011, 1'b1);
      fire(4, lows);
      check("cause_rd", cause_rd, 6'h1a);
      check("hold ok", (lows >= SW_RESET_HOLD_CYCLES - 1) && (lows <= SW_RESET_HOLD_CYCLES + 1), 1);
      check("gating_en_rd", gating_en_rd, 1'b0);
      check("sleep_en_rd", sleep_en_rd, 4'b0000);
      clear_causes(6'h08);
      check("cause_rd", cause_rd, 6'h12);
      // Clear everything after reading, so later causes build up from no flags set
      clear_causes(6'h3f);
      check("cause_rd", cause_rd, 6'h00);
      exp = 6'h00;
      for (int k = 0; k < 4; k++) begin
         fire(ev[k], lows);
         exp[bitpos[k]] = 1'b1;
         check("cause_rd", cause_rd, exp);
      end
      fire(0, lows);
      check("cause_rd", cause_rd, 6'h01);
      $display("test reset causes done");
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
